//--- tw_top.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module tw_top #(
  parameter int QUARTER = tw_pkg::QUARTER_CYC,
  parameter int RELEASE = tw_pkg::RELEASE_CYC
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire pins, open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        alert_in,
  // System
  input  wire logic        deep_sleep,
  output logic             wake_req,
  output logic             irq
);
  logic [2:0] pins;
  logic       scl_s;
  logic       sda_s;
  logic       alert_s;
  tw_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({alert_in, sda_in, scl_in}),
    .level   (pins)
  );
  assign scl_s   = pins[0];
  assign sda_s   = pins[1];
  assign alert_s = pins[2];

  // Register bus
  logic                     acc;
  logic                     wr;
  logic                     m_en_pulse;
  logic                     m_dis_pulse;
  logic                     m_start_pulse;
  logic [15:0]              mcmd;
  logic [7:0]               txdata;
  logic [tw_pkg::NUM_EVT-1:0] evt;
  logic [tw_pkg::NUM_EVT-1:0] mask;
  logic [tw_pkg::NUM_EVT-1:0] set_evt;
  logic [15:0]              sctrl;
  logic                     idle;
  logic [31:0]              next_rdata;
  logic                     unmapped;

  assign acc = psel && penable && !pready;
  assign wr  = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= tw_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      prdata  <= acc ? next_rdata : tw_pkg::ZERO_WORD;
      pslverr <= acc && unmapped;
    end
  end

  always_comb
  begin
    next_rdata = tw_pkg::ZERO_WORD;
    unmapped   = 1'b0;
    if (paddr == tw_pkg::ADDR_MCTRL)
      next_rdata = tw_pkg::ZERO_WORD;
    else if (paddr == tw_pkg::ADDR_MCMD)
      next_rdata = {16'h0000, mcmd};
    else if (paddr == tw_pkg::ADDR_MTXDATA)
      next_rdata = {24'h000000, txdata};
    else if (paddr == tw_pkg::ADDR_STATUS)
    begin
      next_rdata[tw_pkg::NUM_EVT-1:0] = evt;
      next_rdata[tw_pkg::ST_IDLE]     = idle;
    end
    else if (paddr == tw_pkg::ADDR_IMR)
    begin
      next_rdata[tw_pkg::NUM_EVT-1:0] = mask;
      next_rdata[tw_pkg::ST_STOP]     = 1'b0;
    end
    else if (paddr == tw_pkg::ADDR_MVERSION)
      next_rdata = tw_pkg::VERSION_VALUE;
    else if (paddr == tw_pkg::ADDR_SCTRL)
      next_rdata = {16'h0000, sctrl};
    else if (paddr == tw_pkg::ADDR_SVERSION)
      next_rdata = tw_pkg::VERSION_VALUE;
    else
      unmapped = 1'b1;
  end

  assign m_en_pulse    = wr && paddr == tw_pkg::ADDR_MCTRL && pwdata[tw_pkg::MCTRL_EN];
  assign m_dis_pulse   = wr && paddr == tw_pkg::ADDR_MCTRL && pwdata[tw_pkg::MCTRL_DIS];
  assign m_start_pulse = wr && paddr == tw_pkg::ADDR_MCTRL && pwdata[tw_pkg::MCTRL_START];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcmd   <= 16'h0000;
      txdata <= 8'h00;
      mask   <= '0;
      sctrl  <= 16'h0000;
    end
    else if (wr)
    begin
      if (paddr == tw_pkg::ADDR_MCMD)
        mcmd <= pwdata[15:0];
      if (paddr == tw_pkg::ADDR_MTXDATA)
        txdata <= pwdata[7:0];
      if (paddr == tw_pkg::ADDR_IMR)
        mask <= pwdata[tw_pkg::NUM_EVT-1:0];
      if (paddr == tw_pkg::ADDR_SCTRL)
        sctrl <= {1'b0, pwdata[14:8], 4'h0, pwdata[3:0]};
    end
  end

  // Sticky events, set wins over a write-one clear
  logic [tw_pkg::NUM_EVT-1:0] clr_evt;
  assign clr_evt = (wr && paddr == tw_pkg::ADDR_STATUS) ?
                   pwdata[tw_pkg::NUM_EVT-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt <= '0;
      irq <= 1'b0;
    end
    else
    begin
      evt <= (evt & ~clr_evt) | set_evt;
      irq <= |(evt & mask);
    end
  end

  // Master engine
  localparam logic [1:0] Q_LAST_c = tw_pkg::Q_LAST;
  tw_pkg::tw_mstate_t mstate;
  logic       tick;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic [7:0] left;
  logic       m_scl_low;
  logic       m_sda_low;
  logic       ev_done;
  logic       ev_nak;
  logic       ev_stop;
  logic [$clog2(RELEASE)-1:0] rel_cnt;

  tw_div #(.DIV(QUARTER)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (mstate != tw_pkg::TW_M_OFF && mstate != tw_pkg::TW_M_IDLE
              && mstate != tw_pkg::TW_M_REL),
    .tick    (tick)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mstate    <= tw_pkg::TW_M_OFF;
      q         <= 2'h0;
      bitn      <= 4'h0;
      shreg     <= 8'h00;
      left      <= 8'h00;
      m_scl_low <= 1'b1;
      m_sda_low <= 1'b1;
      idle      <= 1'b0;
      ev_done   <= 1'b0;
      ev_nak    <= 1'b0;
      ev_stop   <= 1'b0;
      rel_cnt   <= '0;
    end
    else
    begin
      ev_done <= 1'b0;
      ev_nak  <= 1'b0;
      ev_stop <= 1'b0;
      if (m_dis_pulse)
      begin
        mstate    <= tw_pkg::TW_M_REL;
        m_scl_low <= 1'b0;
        m_sda_low <= 1'b0;
        idle      <= 1'b0;
        rel_cnt   <= '0;
      end
      else
      begin
        case (mstate)
          tw_pkg::TW_M_OFF:
          begin
            m_scl_low <= 1'b1;
            m_sda_low <= 1'b1;
            if (m_en_pulse)
            begin
              mstate    <= tw_pkg::TW_M_IDLE;
              m_scl_low <= 1'b0;
              m_sda_low <= 1'b0;
              idle      <= 1'b1;
            end
          end
          tw_pkg::TW_M_REL:
          begin
            if (m_en_pulse)
            begin
              mstate <= tw_pkg::TW_M_IDLE;
              idle   <= 1'b1;
            end
            else if (rel_cnt == $clog2(RELEASE)'(RELEASE - 1))
              mstate <= tw_pkg::TW_M_OFF;
            else
              rel_cnt <= rel_cnt + 1'b1;
          end
          tw_pkg::TW_M_IDLE:
          begin
            if (m_start_pulse)
            begin
              mstate <= tw_pkg::TW_M_START;
              idle   <= 1'b0;
              q      <= 2'h0;
              shreg  <= {mcmd[6:0], 1'b0};
              left   <= mcmd[tw_pkg::MCMD_CNT_LSB +: 8];
            end
          end
          tw_pkg::TW_M_START:
          begin
            if (tick)
            begin
              q         <= q + 1'b1;
              m_sda_low <= 1'b1;
              if (q == Q_LAST_c)
              begin
                mstate    <= tw_pkg::TW_M_BIT;
                m_scl_low <= 1'b1;
                bitn      <= 4'h0;
              end
            end
          end
          tw_pkg::TW_M_BIT:
          begin
            if (tick)
            begin
              q <= q + 1'b1;
              if (q == 2'h0)
                m_sda_low <= !shreg[7];
              else if (q == 2'h1)
                m_scl_low <= 1'b0;
              else if (q == Q_LAST_c)
              begin
                m_scl_low <= 1'b1;
                shreg     <= {shreg[6:0], 1'b0};
                bitn      <= bitn + 1'b1;
                if (bitn == tw_pkg::BIT_LAST)
                  mstate <= tw_pkg::TW_M_ACK;
              end
            end
          end
          tw_pkg::TW_M_ACK:
          begin
            if (tick)
            begin
              q <= q + 1'b1;
              if (q == 2'h0)
                m_sda_low <= 1'b0;
              else if (q == 2'h1)
                m_scl_low <= 1'b0;
              else if (q == 2'h2 && sda_s && left != 8'h00)
              begin
                idle   <= 1'b1;
                ev_nak <= 1'b1;
              end
              else if (q == Q_LAST_c)
              begin
                m_scl_low <= 1'b1;
                bitn      <= 4'h0;
                if (sda_s || left == 8'h00)
                begin
                  mstate <= tw_pkg::TW_M_STOP;
                  ev_nak <= sda_s && left == 8'h00;
                end
                else
                begin
                  mstate <= tw_pkg::TW_M_BIT;
                  shreg  <= txdata;
                  left   <= left - 1'b1;
                end
              end
            end
          end
          tw_pkg::TW_M_STOP:
          begin
            if (tick)
            begin
              q <= q + 1'b1;
              if (q == 2'h0)
                m_sda_low <= 1'b1;
              else if (q == 2'h1)
                m_scl_low <= 1'b0;
              else if (q == Q_LAST_c)
              begin
                m_sda_low <= 1'b0;
                mstate    <= tw_pkg::TW_M_IDLE;
                idle      <= 1'b1;
                ev_stop   <= 1'b1;
                ev_done   <= 1'b1;
              end
            end
          end
          default:
            mstate <= tw_pkg::TW_M_OFF;
        endcase
      end
    end
  end

  // Slave address matcher, sampling the bus through the synchroniser
  tw_pkg::tw_sstate_t sstate;
  logic       scl_d;
  logic       sda_d;
  logic [7:0] srx;
  logic [3:0] scnt;
  logic       s_sda_low;
  logic       s_scl_low;
  logic       ev_saddr;
  logic       ev_alert;
  logic       alert_d;
  logic       start_c;
  logic       stop_c;
  logic       scl_rise;
  logic       scl_fall;

  assign start_c  = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c   = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      alert_d <= 1'b1; // Same as synchroniser reset, no false edge
    end
    else
    begin
      scl_d   <= scl_s;
      sda_d   <= sda_s;
      alert_d <= alert_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sstate    <= tw_pkg::TW_S_IDLE;
      srx       <= 8'h00;
      scnt      <= 4'h0;
      s_sda_low <= 1'b0;
      ev_saddr  <= 1'b0;
    end
    else
    begin
      ev_saddr <= 1'b0;
      if (!sctrl[tw_pkg::SCTRL_EN] || stop_c)
      begin
        sstate    <= tw_pkg::TW_S_IDLE;
        s_sda_low <= 1'b0;
      end
      else if (start_c)
      begin
        sstate    <= tw_pkg::TW_S_ADDR;
        scnt      <= 4'h0;
        s_sda_low <= 1'b0;
      end
      else
      begin
        case (sstate)
          tw_pkg::TW_S_ADDR:
          begin
            if (scl_rise)
            begin
              srx  <= {srx[6:0], sda_s};
              scnt <= scnt + 1'b1;
            end
            else if (scl_fall && scnt == 4'h8)
            begin
              if (srx[7:1] == sctrl[tw_pkg::SCTRL_ADDR_LSB +: 7])
              begin
                sstate    <= tw_pkg::TW_S_ACK;
                s_sda_low <= 1'b1;
                ev_saddr  <= 1'b1;
              end
              else
                sstate <= tw_pkg::TW_S_WAIT;
            end
          end
          tw_pkg::TW_S_ACK:
          begin
            if (scl_fall)
            begin
              s_sda_low <= 1'b0;
              sstate    <= tw_pkg::TW_S_WAIT;
            end
          end
          default:
            sstate <= sstate;
        endcase
      end
    end
  end

  // Stretch clock after own address until software clears the event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_scl_low <= 1'b0;
    else
      s_scl_low <= sctrl[tw_pkg::SCTRL_STREN] && evt[tw_pkg::ST_SADDR]
                   && sstate == tw_pkg::TW_S_WAIT && !scl_s;
  end

  // Alert rises, active high, ignored when pins are shared
  assign ev_alert = alert_s && !alert_d
                    && !sctrl[tw_pkg::SCTRL_SHARED];

  always_comb
  begin
    set_evt                  = '0;
    set_evt[tw_pkg::ST_DONE]  = ev_done;
    set_evt[tw_pkg::ST_NAK]   = ev_nak;
    set_evt[tw_pkg::ST_STOP]  = ev_stop;
    set_evt[tw_pkg::ST_ALERT] = ev_alert;
    set_evt[tw_pkg::ST_SADDR] = ev_saddr;
  end

  // Pins and wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
      scl_oe   <= 1'b1;
      sda_oe   <= 1'b1;
      wake_req <= 1'b0;
    end
    else
    begin
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
      scl_oe   <= m_scl_low || s_scl_low;
      sda_oe   <= m_sda_low || s_sda_low;
      wake_req <= ev_saddr && !(deep_sleep && sctrl[tw_pkg::SCTRL_STREN]
                  && sctrl[tw_pkg::SCTRL_SOAM]);
    end
  end
endmodule // tw_top

//--- tw_pkg.sv
// Operation
// - Mask register reads stop bit as zero
// - Disabled master pulls both lines low
// - NAK with bytes left sets idle at once
// - Disable write releases both lines high immediately
// - Bus alert input is active high
// - Alert unusable when master and slave share pins
// - No deep-sleep wake with stretch plus stop-on-match
// - Both version registers read zero
package tw_pkg;
  localparam logic [7:0] ADDR_MCTRL    = 8'h00;
  localparam logic [7:0] ADDR_MCMD     = 8'h04;
  localparam logic [7:0] ADDR_MTXDATA  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_IMR      = 8'h10;
  localparam logic [7:0] ADDR_MVERSION = 8'h14;
  localparam logic [7:0] ADDR_SCTRL    = 8'h20;
  localparam logic [7:0] ADDR_SVERSION = 8'h24;
  // Control bits of the master control register
  localparam int MCTRL_EN    = 0;
  localparam int MCTRL_DIS   = 1;
  localparam int MCTRL_START = 2;
  // Slave control fields and the master command count field
  localparam int SCTRL_EN     = 0;
  localparam int SCTRL_STREN  = 1;
  localparam int SCTRL_SOAM   = 2;
  localparam int SCTRL_SHARED = 3;
  localparam int SCTRL_ADDR_LSB = 8;
  localparam int MCMD_CNT_LSB   = 8;
  // Status and mask layout
  localparam int ST_DONE  = 0;
  localparam int ST_NAK   = 1;
  localparam int ST_STOP  = 2;
  localparam int ST_ALERT = 3;
  localparam int ST_SADDR = 4;
  localparam int ST_IDLE  = 8;
  localparam int NUM_EVT  = 5;
  localparam logic [31:0] VERSION_VALUE = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  // Timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int BUS_PERIOD_NS  = 10000;
  localparam int QUARTER_CYC    = BUS_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int RELEASE_CYC    = BUS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;

  typedef enum logic [2:0] {
    TW_M_OFF   = 3'b000,
    TW_M_IDLE  = 3'b001,
    TW_M_START = 3'b010,
    TW_M_BIT   = 3'b011,
    TW_M_ACK   = 3'b100,
    TW_M_STOP  = 3'b101,
    TW_M_REL   = 3'b110
  } tw_mstate_t;

  typedef enum logic [1:0] {
    TW_S_IDLE = 2'b00,
    TW_S_ADDR = 2'b01,
    TW_S_ACK  = 2'b10,
    TW_S_WAIT = 2'b11
  } tw_sstate_t;
endpackage

//--- tw_sync.sv
`timescale 1ns/100ps
module tw_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Raw and filtered levels
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1       <= 1'b1;
          s2       <= 1'b1;
          s3       <= 1'b1;
          level[i] <= 1'b1;
        end
        else
        begin
          s1 <= raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            level[i] <= s3;
        end
      end
    end
  endgenerate
endmodule // tw_sync

//--- tw_div.sv
`timescale 1ns/100ps
module tw_div #(
  parameter int DIV = 125
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Run and phase tick
  input  wire logic run,
  output logic      tick
);
  logic [$clog2(DIV)-1:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt == $clog2(DIV)'(DIV - 1))
    begin
      cnt  <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // tw_div

//--- tw_sva.sv
`timescale 1ns/100ps
module tw_sva #(
  parameter int QUARTER = 4,
  parameter int RELEASE = 8
) (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Two-wire pins
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        alert_in,
  // System
  input wire logic        deep_sleep,
  input wire logic        wake_req,
  input wire logic        irq
);
  localparam int REL_MAX = RELEASE + 6;
  logic       wr_ok;
  logic       rd_ok;
  logic       dis_wr;
  logic [4:0] mask_q;
  logic       stren_q;
  logic       soam_q;
  assign wr_ok  = psel && penable && pready && pwrite;
  assign rd_ok  = psel && penable && pready && !pwrite;
  assign dis_wr = wr_ok && paddr == tw_pkg::ADDR_MCTRL && pwdata[tw_pkg::MCTRL_DIS];
  // Shadow of what software wrote to mask and slave setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q  <= 5'h00;
      stren_q <= 1'h0;
      soam_q  <= 1'h0;
    end
    else if (wr_ok && paddr == tw_pkg::ADDR_IMR)
      mask_q <= pwdata[4:0];
    else if (wr_ok && paddr == tw_pkg::ADDR_SCTRL)
    begin
      stren_q <= pwdata[tw_pkg::SCTRL_STREN];
      soam_q  <= pwdata[tw_pkg::SCTRL_SOAM];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_drive_a: assert property ($rose(presetn) |-> scl_oe && sda_oe)
    else $error("lines not pulled low after reset");
  disable_release_a: assert property (dis_wr |-> ##[1:2] (!scl_oe && !sda_oe)
    ##1 (!scl_oe && !sda_oe) [*3]) else $error("disable did not release lines");
  off_low_a: assert property (dis_wr |-> ##[4:REL_MAX] (scl_oe && sda_oe))
    else $error("disabled master not driving low");
  imr_stop_a: assert property (rd_ok && paddr == tw_pkg::ADDR_IMR
    |-> prdata[4:0] == {mask_q[4:3], 1'h0, mask_q[1:0]}) else $error("mask readback wrong");
  mver_zero_a: assert property (rd_ok && paddr == tw_pkg::ADDR_MVERSION |-> prdata == 32'h0)
    else $error("master version not zero");
  sver_zero_a: assert property (rd_ok && paddr == tw_pkg::ADDR_SVERSION |-> prdata == 32'h0)
    else $error("slave version not zero");
  wake_block_a: assert property (wake_req |-> !(deep_sleep && stren_q && soam_q))
    else $error("wake with stretch and stop-on-match");
  open_drain_a: assert property (!scl_out && !sda_out)
    else $error("pin output value not zero");
  cover property (wake_req);
  cover property ($rose(irq));
  cover property (dis_wr);
endmodule // tw_sva

bind tw_top tw_sva #(.QUARTER(QUARTER), .RELEASE(RELEASE)) sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .alert_in(alert_in), .deep_sleep(deep_sleep),
  .wake_req(wake_req), .irq(irq));

//--- tw_dev.sv
`timescale 1ns/100ps
module tw_dev #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bus lines and behaviour
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nak_data,
  output logic            sda_oe,
  output logic            in_frame,
  output logic [7:0]      last_byte
);
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic [3:0] bitn;
  logic [7:0] sh;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {scl_q, sda_q, first, in_frame, sda_oe} <= 5'h18;
      bitn      <= 4'h0;
      sh        <= 8'h00;
      last_byte <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        in_frame <= 1'h1;
        first    <= 1'h1;
        // Clock fall after start wraps this to the first bit
        bitn     <= 4'hF;
      end
      else if (scl && scl_q && !sda_q && sda)
      begin
        in_frame <= 1'h0;
        sda_oe   <= 1'h0;
      end
      else if (in_frame && scl && !scl_q && bitn != 4'h8)
        sh <= {sh[6:0], sda};
      else if (in_frame && !scl && scl_q)
      begin
        // Ack or nak driven only through the ninth bit
        if (bitn == 4'h7)
        begin
          sda_oe    <= first ? (sh == {DEV_ADDR, 1'h0}) : !nak_data;
          last_byte <= sh;
          if (first && sh != {DEV_ADDR, 1'h0})
            in_frame <= 1'h0;
        end
        else
          sda_oe <= 1'h0;
        if (bitn == 4'h8)
          first <= 1'h0;
        bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      end
    end
  end
endmodule // tw_dev

//--- two_wire_master_slave_quirks_test.sv
`timescale 1ns/100ps
module two_wire_master_slave_quirks_test;
  localparam int QUARTER = 4;
  localparam int RELEASE = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, last_byte;
  logic [31:0] pwdata, prdata, r;
  logic        scl_out, scl_oe, sda_out, sda_oe, alert_in, deep_sleep, wake_req, irq;
  logic        dev_oe, nak_data, in_frame, scl_w, sda_w;
  int          mismatches, checked, wakes;
  // Pulled-up wired-and lines
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || dev_oe);
  initial
  begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (wake_req === 1'h1) wakes <= wakes + 1;
  tw_top #(.QUARTER(QUARTER), .RELEASE(RELEASE)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_in(alert_in), .deep_sleep(deep_sleep), .wake_req(wake_req), .irq(irq));
  tw_dev dev_u (.pclk(pclk), .presetn(presetn), .scl(scl_w), .sda(sda_w),
    .nak_data(nak_data), .sda_oe(dev_oe), .in_frame(in_frame), .last_byte(last_byte));
  task automatic results;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 20)
    begin
      mismatches++;
      results();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  // Poll for idle, optionally clearing the slave match to end a stretch
  task automatic wait_idle(input logic clr);
    int n;
    n = 0;
    do
    begin
      rd(tw_pkg::ADDR_STATUS);
      if (clr && r[tw_pkg::ST_IDLE] !== 1'h1)
        wr(tw_pkg::ADDR_STATUS, 32'h10);
      n++;
    end
    while (r[tw_pkg::ST_IDLE] !== 1'h1 && n < 300);
    if (n >= 300)
    begin
      mismatches++;
      results();
    end
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] n, input logic [7:0] d);
    wr(tw_pkg::ADDR_MTXDATA, {24'h0, d});
    wr(tw_pkg::ADDR_MCMD, {16'h0, n, 1'h0, a});
    wr(tw_pkg::ADDR_MCTRL, 32'h4);
  endtask
  task automatic t_regs;
    chk("lines after reset", 32'h3, {30'h0, scl_oe, sda_oe});
    rd(tw_pkg::ADDR_STATUS);
    chk("status after reset", 32'h0, r);
    rd(tw_pkg::ADDR_MVERSION);
    chk("master version", 32'h0, r);
    rd(tw_pkg::ADDR_SVERSION);
    chk("slave version", 32'h0, r);
    rd(8'h30);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(tw_pkg::ADDR_IMR, 32'h1F);
    rd(tw_pkg::ADDR_IMR);
    chk("mask readback", 32'h1B, r);
  endtask
  task automatic t_xfer;
    wr(tw_pkg::ADDR_MCTRL, 32'h1);
    wr(tw_pkg::ADDR_IMR, 32'h0);
    xfer(7'h2A, 8'h1, 8'hA5);
    wait_idle(1'h0);
    chk("byte seen", 32'hA5, {24'h0, last_byte});
    rd(tw_pkg::ADDR_STATUS);
    chk("done and stop", 32'h5, {29'h0, r[2:0]});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(tw_pkg::ADDR_IMR, 32'h1);
    @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(tw_pkg::ADDR_STATUS, 32'h1F);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  task automatic t_alert;
    alert_in <= 1'h1;
    repeat (6) @(posedge pclk);
    rd(tw_pkg::ADDR_STATUS);
    chk("alert on high", 32'h1, {31'h0, r[tw_pkg::ST_ALERT]});
    alert_in <= 1'h0;
    wr(tw_pkg::ADDR_STATUS, 32'h8);
    wr(tw_pkg::ADDR_SCTRL, 32'h8);
    alert_in <= 1'h1;
    repeat (6) @(posedge pclk);
    rd(tw_pkg::ADDR_STATUS);
    chk("alert when shared", 32'h0, {31'h0, r[tw_pkg::ST_ALERT]});
    alert_in <= 1'h0;
    wr(tw_pkg::ADDR_SCTRL, 32'h0);
  endtask
  task automatic t_nak;
    nak_data <= 1'h1;
    xfer(7'h2A, 8'h2, 8'h3C);
    wait_idle(1'h0);
    rd(tw_pkg::ADDR_STATUS);
    chk("nak flag", 32'h1, {31'h0, r[tw_pkg::ST_NAK]});
    chk("idle before stop", 32'h1, {31'h0, in_frame});
    repeat (8 * QUARTER) @(posedge pclk);
    chk("stop after nak", 32'h0, {31'h0, in_frame});
    nak_data <= 1'h0;
  endtask
  task automatic t_wake;
    deep_sleep <= 1'h1;
    wr(tw_pkg::ADDR_SCTRL, 32'h3301);
    wakes = 0;
    xfer(7'h33, 8'h0, 8'h00);
    wait_idle(1'h1);
    chk("wake on match", 32'h1, 32'(wakes));
    wr(tw_pkg::ADDR_SCTRL, 32'h3307);
    wakes = 0;
    xfer(7'h33, 8'h0, 8'h00);
    wait_idle(1'h1);
    chk("wake blocked", 32'h0, 32'(wakes));
    wr(tw_pkg::ADDR_SCTRL, 32'h0);
    deep_sleep <= 1'h0;
  endtask
  task automatic t_disable;
    xfer(7'h2A, 8'h2, 8'h55);
    repeat (40) @(posedge pclk);
    wr(tw_pkg::ADDR_MCTRL, 32'h2);
    @(posedge pclk);
    chk("released on disable", 32'h0, {30'h0, scl_oe, sda_oe});
    repeat (RELEASE + 4) @(posedge pclk);
    chk("low when disabled", 32'h3, {30'h0, scl_oe, sda_oe});
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, alert_in, deep_sleep, nak_data} = 7'h0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    mismatches = 0;
    checked    = 0;
    wakes      = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_xfer();
    t_alert();
    t_nak();
    t_wake();
    t_disable();
    results();
  end
endmodule // two_wire_master_slave_quirks_test
